// ### tcl_pkg.sv
// Package for the tag configuration and lock register block
package tcl_pkg;

  // Register byte addresses on the serial-bus system area
  localparam logic [11:0] TCL_ADDR_WP_LO   = 12'h800;
  localparam logic [11:0] TCL_ADDR_WP_HI   = 12'h801;
  localparam logic [11:0] TCL_ADDR_CFG     = 12'h910;
  localparam logic [11:0] TCL_ADDR_CTRL    = 12'h920;

  // Reset and delivery values
  localparam logic [15:0] TCL_WP_RESET     = 16'h0000;
  localparam logic [7:0]  TCL_CFG_RESET    = 8'hF4;
  localparam logic [7:0]  TCL_ZERO_BYTE    = 8'h00;

  // Configuration byte fields
  localparam int          TCL_CFG_PIN_MODE = 3;
  localparam int          TCL_CFG_HV_OFF   = 2;
  localparam int          TCL_CFG_LVL_HI   = 1;
  localparam int          TCL_CFG_LVL_LO   = 0;
  localparam logic [7:0]  TCL_CFG_HV_MASK  = 8'h07;
  localparam logic [7:0]  TCL_CFG_PIN_MASK = 8'h08;

  // Control register fields
  localparam int          TCL_CTRL_DONE    = 7;
  localparam int          TCL_CTRL_FIELD   = 1;
  localparam int          TCL_CTRL_HV_EN   = 0;

  // Activity pin modes
  localparam logic        TCL_MODE_BUSY    = 1'b0;
  localparam logic        TCL_MODE_WIP     = 1'b1;

  // Dedicated RF configuration commands
  typedef enum logic [2:0] {
    TCL_RF_READ_CONFIG   = 3'h0,
    TCL_RF_WRITE_HV_CFG  = 3'h1,
    TCL_RF_WRITE_PIN_CFG = 3'h2,
    TCL_RF_READ_CONTROL  = 3'h3,
    TCL_RF_SET_HV_EN     = 3'h4
  } tcl_rf_cmd_e;

  // Activity pin state, one-hot
  typedef enum logic [2:0] {
    TCL_ACT_IDLE = 3'b001,
    TCL_ACT_BUSY = 3'b010,
    TCL_ACT_WIP  = 3'b100
  } tcl_act_e;

  // RF frame events, one-cycle pulses from the RF front end
  typedef struct packed {
    logic sof;
    logic crc_rcvd;
    logic cmd_bad;
    logic exec_done;
    logic write_start;
    logic answer_start;
  } tcl_rf_evt_s;

  // Serial-bus register request
  typedef struct packed {
    logic        req;
    logic        we;
    logic        system_area_select;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } tcl_bus_req_s;

  // RF configuration command request
  typedef struct packed {
    logic        valid;
    tcl_rf_cmd_e cmd;
    logic [7:0]  wdata;
  } tcl_rf_req_s;

endpackage

// ### tcl_sync.sv
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module tcl_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_arst_n,
  // Data
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule // tcl_sync

// ### tcl_regs.sv
// Sector write-protect, configuration and control registers with activity pin
`timescale 1ns/1ps
module tcl_regs
  import tcl_pkg::*;
(
  // Clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_arst_n,
  // Stored non-volatile configuration, sampled after reset
  input  wire logic [7:0]   i_nv_cfg,
  // Serial-bus register port
  input  wire tcl_bus_req_s i_bus,
  input  wire logic         i_bus_pwd_ok,
  input  wire logic         i_bus_cmd_active,
  input  wire logic         i_bus_write_active,
  output logic              o_bus_ack,
  output logic              o_bus_err,
  output logic [7:0]        o_bus_rdata,
  // Write cycle events
  input  wire logic         i_wr_cycle_start,
  input  wire logic         i_wr_cycle_ok,
  // RF command port
  input  wire tcl_rf_req_s  i_rf,
  input  wire tcl_rf_evt_s  i_rf_evt,
  input  wire logic         i_rf_field_on,
  output logic              o_rf_ack,
  output logic [7:0]        o_rf_rdata,
  // Non-volatile store request
  output logic              o_cfg_store,
  output logic [7:0]        o_cfg_store_data,
  // Protection and analog controls
  output logic [15:0]       o_sector_wp,
  output logic              o_harvest_out_en,
  output logic [1:0]        o_harvest_sink_level,
  output logic              o_rf_activity_pin
);

  logic [15:0] wp_q;
  logic [7:0]  cfg_q;
  logic [7:0]  cfg_d;
  logic        hv_en_q;
  logic        done_q;
  logic        load_q;
  logic        field_s;
  tcl_act_e    act_q;
  tcl_act_e    act_d;
  logic        pull_d;

  // Field indicator comes from the analog detector
  tcl_sync #(
    .W (1)
  ) u_field_sync (
    .i_clk_sys (i_clk_sys),
    .i_arst_n  (i_arst_n),
    .i_async   (i_rf_field_on),
    .o_sync    (field_s)
  );

  // Serial-bus decode; system-area select must be set
  function automatic logic bus_hit(input tcl_bus_req_s b, input logic [11:0] a);
    bus_hit = b.req && b.system_area_select && (b.addr == a);
  endfunction

  logic hit_wp_lo;
  logic hit_wp_hi;
  logic hit_cfg;
  logic hit_ctrl;
  logic wp_wr_ok;

  assign hit_wp_lo = bus_hit(i_bus, TCL_ADDR_WP_LO);
  assign hit_wp_hi = bus_hit(i_bus, TCL_ADDR_WP_HI);
  assign hit_cfg   = bus_hit(i_bus, TCL_ADDR_CFG);
  assign hit_ctrl  = bus_hit(i_bus, TCL_ADDR_CTRL);
  assign wp_wr_ok  = i_bus.we && i_bus_pwd_ok;

  logic rf_wr_hv;
  logic rf_wr_pin;
  logic rf_set_en;

  assign rf_wr_hv  = i_rf.valid && (i_rf.cmd == TCL_RF_WRITE_HV_CFG);
  assign rf_wr_pin = i_rf.valid && (i_rf.cmd == TCL_RF_WRITE_PIN_CFG);
  assign rf_set_en = i_rf.valid && (i_rf.cmd == TCL_RF_SET_HV_EN);

  // One-shot load of stored settings just after reset release
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      load_q <= 1'b1;
    end else begin
      load_q <= 1'b0;
    end
  end

  // Sector write-protect word, low byte is sectors 7-0
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wp_q <= TCL_WP_RESET;
    end else begin
      if (hit_wp_lo && wp_wr_ok) begin
        wp_q[7:0] <= i_bus.wdata;
      end
      if (hit_wp_hi && wp_wr_ok) begin
        wp_q[15:8] <= i_bus.wdata;
      end
    end
  end

  // Configuration byte; don't-care upper nibble is kept as written
  // Next value is shared with the store request so both see the same byte
  always_comb begin
    cfg_d = cfg_q;
    if (load_q) begin
      cfg_d = i_nv_cfg;
    end else if (hit_cfg && i_bus.we) begin
      cfg_d = i_bus.wdata;
    end else if (rf_wr_hv) begin
      cfg_d = (cfg_q & ~TCL_CFG_HV_MASK) | (i_rf.wdata & TCL_CFG_HV_MASK);
    end else if (rf_wr_pin) begin
      cfg_d = (cfg_q & ~TCL_CFG_PIN_MASK) | (i_rf.wdata & TCL_CFG_PIN_MASK);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg_q <= TCL_CFG_RESET;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // Harvest enable; bus write wins over a same-cycle RF write
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hv_en_q <= 1'b0;
    end else if (load_q) begin
      hv_en_q <= ~i_nv_cfg[TCL_CFG_HV_OFF];
    end else if (hit_ctrl && i_bus.we) begin
      hv_en_q <= i_bus.wdata[TCL_CTRL_HV_EN];
    end else if (rf_set_en) begin
      hv_en_q <= i_rf.wdata[TCL_CTRL_HV_EN];
    end
  end

  // Write-done flag; completion wins over a coincident start
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      done_q <= 1'b0;
    end else if (i_wr_cycle_ok) begin
      done_q <= 1'b1;
    end else if (i_wr_cycle_start) begin
      done_q <= 1'b0;
    end
  end

  // Serial-bus answer, one cycle after the request
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_bus_ack   <= 1'b0;
      o_bus_err   <= 1'b0;
      o_bus_rdata <= TCL_ZERO_BYTE;
    end else begin
      o_bus_ack   <= i_bus.req;
      o_bus_err   <= 1'b0;
      o_bus_rdata <= TCL_ZERO_BYTE;
      if (hit_wp_lo || hit_wp_hi) begin
        o_bus_err <= i_bus.we && !i_bus_pwd_ok;
        if (!i_bus.we) begin
          o_bus_rdata <= hit_wp_hi ? wp_q[15:8] : wp_q[7:0];
        end
      end else if (hit_cfg) begin
        if (!i_bus.we) begin
          o_bus_rdata <= cfg_q;
        end
      end else if (hit_ctrl) begin
        if (!i_bus.we) begin
          o_bus_rdata <= {done_q, 5'b00000, field_s, hv_en_q};
        end
      end else if (i_bus.req) begin
        o_bus_err <= 1'b1;
      end
    end
  end

  // RF command answer, one cycle after the command
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rf_ack   <= 1'b0;
      o_rf_rdata <= TCL_ZERO_BYTE;
    end else begin
      o_rf_ack   <= i_rf.valid;
      o_rf_rdata <= TCL_ZERO_BYTE;
      if (i_rf.valid) begin
        case (i_rf.cmd)
          TCL_RF_READ_CONFIG: begin
            o_rf_rdata <= cfg_q;
          end
          TCL_RF_READ_CONTROL: begin
            o_rf_rdata <= {1'b0, 5'b00000, 1'b1, hv_en_q};
          end
          default: begin
            o_rf_rdata <= TCL_ZERO_BYTE;
          end
        endcase
      end
    end
  end

  // Store request toward the non-volatile array on any config write
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_cfg_store      <= 1'b0;
      o_cfg_store_data <= TCL_ZERO_BYTE;
    end else begin
      o_cfg_store      <= !load_q && ((hit_cfg && i_bus.we) || rf_wr_hv || rf_wr_pin);
      o_cfg_store_data <= cfg_d;
    end
  end

  // Activity state; field loss always drops back to idle
  always_comb begin
    act_d = act_q;
    case (act_q)
      TCL_ACT_IDLE: begin
        if (!field_s) begin
          act_d = TCL_ACT_IDLE;
        end else if (cfg_q[TCL_CFG_PIN_MODE] == TCL_MODE_BUSY && i_rf_evt.sof) begin
          act_d = TCL_ACT_BUSY;
        end else if (cfg_q[TCL_CFG_PIN_MODE] == TCL_MODE_WIP && i_rf_evt.write_start) begin
          act_d = TCL_ACT_WIP;
        end
      end
      TCL_ACT_BUSY: begin
        if (!field_s) begin
          act_d = TCL_ACT_IDLE;
        end else if (i_rf_evt.exec_done) begin
          act_d = TCL_ACT_IDLE;
        end else if (i_rf_evt.crc_rcvd && i_rf_evt.cmd_bad) begin
          act_d = TCL_ACT_IDLE;
        end
      end
      TCL_ACT_WIP: begin
        if (!field_s || i_rf_evt.answer_start) begin
          act_d = TCL_ACT_IDLE;
        end
      end
      default: begin
        act_d = TCL_ACT_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      act_q <= TCL_ACT_IDLE;
    end else begin
      act_q <= act_d;
    end
  end

  // Serial-bus activity masks the pull: a bus command in busy mode, a bus write in WIP mode
  always_comb begin
    pull_d = 1'b0;
    if (act_d == TCL_ACT_BUSY) begin
      pull_d = !i_bus_cmd_active;
    end else if (act_d == TCL_ACT_WIP) begin
      pull_d = !i_bus_write_active;
    end
  end

  // Registered outputs
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rf_activity_pin    <= 1'b0;
      o_harvest_out_en     <= 1'b0;
      o_harvest_sink_level <= 2'b00;
      o_sector_wp          <= TCL_WP_RESET;
    end else begin
      o_rf_activity_pin    <= pull_d;
      o_harvest_out_en     <= hv_en_q;
      o_harvest_sink_level <= {cfg_q[TCL_CFG_LVL_HI], cfg_q[TCL_CFG_LVL_LO]};
      o_sector_wp          <= wp_q;
    end
  end

endmodule // tcl_regs

// ### tcl_regs_props.sv
// Checker for the configuration and lock registers
`timescale 1ns/1ps
module tcl_regs_props
  import tcl_pkg::*;
(
  // Clock and reset
  input wire logic         i_clk_sys,
  input wire logic         i_arst_n,
  // Serial-bus side
  input wire tcl_bus_req_s i_bus,
  input wire logic         i_bus_pwd_ok,
  input wire logic         i_bus_cmd_active,
  input wire logic         i_bus_write_active,
  input wire logic         o_bus_ack,
  input wire logic         o_bus_err,
  // RF side
  input wire tcl_rf_req_s  i_rf,
  input wire logic         i_rf_field_on,
  input wire logic         o_rf_ack,
  input wire logic [7:0]   o_rf_rdata,
  input wire logic         o_cfg_store,
  input wire logic [7:0]   o_cfg_store_data,
  input wire logic         o_harvest_out_en,
  input wire logic [1:0]   o_harvest_sink_level,
  input wire logic         o_rf_activity_pin
);
  default clocking dc @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_arst_n);

  bus_ack_a: assert property (i_bus.req |=> o_bus_ack)
    else $error("bus request not acknowledged");
  wp_lock_a: assert property (i_bus.req && i_bus.we && !i_bus_pwd_ok && i_bus.addr[11:1] == 11'h400 |=> o_bus_err)
    else $error("protect write without password accepted");
  rf_ack_a: assert property (i_rf.valid |=> o_rf_ack)
    else $error("rf command not acknowledged");
  rf_ctrl_a: assert property (i_rf.valid && i_rf.cmd == TCL_RF_READ_CONTROL |=> o_rf_rdata[7:1] == 7'h01)
    else $error("rf control read upper bits wrong");
  pin_mask_a: assert property (i_bus_cmd_active && i_bus_write_active |=> !o_rf_activity_pin)
    else $error("activity pin pulled during bus command");
  // Sync adds two cycles, so allow four before demanding release
  field_loss_a: assert property (!i_rf_field_on [*4] |=> !o_rf_activity_pin)
    else $error("activity pin held without field");
  sink_lvl_a: assert property (o_cfg_store |=> o_harvest_sink_level == $past(o_cfg_store_data[1:0]))
    else $error("sink level does not follow new config");
  hv_en_a: assert property (i_rf.valid && i_rf.cmd == TCL_RF_SET_HV_EN && !i_bus.req
    |-> ##2 o_harvest_out_en == $past(i_rf.wdata[0], 2))
    else $error("harvest enable not applied");
endmodule // tcl_regs_props

bind tcl_regs tcl_regs_props tcl_regs_props_inst (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_bus(i_bus),
  .i_bus_pwd_ok(i_bus_pwd_ok), .i_bus_cmd_active(i_bus_cmd_active), .i_bus_write_active(i_bus_write_active),
  .o_bus_ack(o_bus_ack), .o_bus_err(o_bus_err), .i_rf(i_rf), .i_rf_field_on(i_rf_field_on), .o_rf_ack(o_rf_ack),
  .o_rf_rdata(o_rf_rdata), .o_cfg_store(o_cfg_store), .o_cfg_store_data(o_cfg_store_data),
  .o_harvest_out_en(o_harvest_out_en), .o_harvest_sink_level(o_harvest_sink_level),
  .o_rf_activity_pin(o_rf_activity_pin));

// ### tcl_rf_model.sv
// RF front end model: frame events and field level
`timescale 1ns/1ps
module tcl_rf_model
  import tcl_pkg::*;
(
  // Clock
  input  wire logic  i_clk_sys,
  // Events and field
  output tcl_rf_evt_s o_evt,
  output logic        o_field_on
);
  initial begin
    o_evt = '0;
    o_field_on = 1'h0;
  end

  task automatic pulse(input logic [5:0] v);
    @(posedge i_clk_sys) o_evt <= v;
    @(posedge i_clk_sys) o_evt <= '0;
  endtask

  // Extra cycles let the field reach the synchronised side
  task automatic field(input logic v);
    @(posedge i_clk_sys) o_field_on <= v;
    repeat (4) @(posedge i_clk_sys);
  endtask
endmodule // tcl_rf_model

// ### tb.sv
// Self-checking bench for the configuration and lock registers
`timescale 1ns/1ps
module tb;
  import tcl_pkg::*;
  logic         clk, rst_n, pwd, cmd_act, wr_act, wr_start, wr_ok;
  logic         field, bus_ack, bus_err, rf_ack, store, hv_en, pin;
  logic [7:0]   nv_cfg, bus_rd, rf_rd, store_d;
  logic [15:0]  wp;
  logic [1:0]   lvl;
  tcl_bus_req_s bus;
  tcl_rf_req_s  rf;
  tcl_rf_evt_s  evt;
  int           err_count, checked;

  tcl_regs tcl_regs_inst (.i_clk_sys(clk), .i_arst_n(rst_n), .i_nv_cfg(nv_cfg), .i_bus(bus),
    .i_bus_pwd_ok(pwd), .i_bus_cmd_active(cmd_act), .i_bus_write_active(wr_act), .o_bus_ack(bus_ack),
    .o_bus_err(bus_err), .o_bus_rdata(bus_rd), .i_wr_cycle_start(wr_start), .i_wr_cycle_ok(wr_ok),
    .i_rf(rf), .i_rf_evt(evt), .i_rf_field_on(field), .o_rf_ack(rf_ack), .o_rf_rdata(rf_rd),
    .o_cfg_store(store), .o_cfg_store_data(store_d), .o_sector_wp(wp), .o_harvest_out_en(hv_en),
    .o_harvest_sink_level(lvl), .o_rf_activity_pin(pin));
  tcl_rf_model tcl_rf_model_inst (.i_clk_sys(clk), .o_evt(evt), .o_field_on(field));

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Reset with a chosen stored configuration byte
  task automatic apply_reset(input logic [7:0] cfg);
    rst_n  <= 1'h0;
    nv_cfg <= cfg;
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge clk);
  endtask

  // Password and serial-bus activity levels
  task automatic set_masks(input logic p, c, w);
    @(posedge clk) pwd <= p;
    cmd_act <= c;
    wr_act  <= w;
  endtask

  // One-cycle write cycle start and completion pulses
  task automatic wr_cycle(input logic s, ok);
    @(posedge clk) wr_start <= s;
    wr_ok <= ok;
    @(posedge clk) wr_start <= 1'h0;
    wr_ok <= 1'h0;
  endtask

  // Request is taken at the next edge; answer stands for one cycle after it
  task automatic bw(input logic we, sel, input logic [11:0] a, input logic [7:0] d, e, input logic er);
    @(posedge clk) bus <= {1'h1, we, sel, a, d};
    @(posedge clk) bus.req <= 1'h0;
    #1 chk(bus_ack, 1'h1);
    chk(bus_err, er);
    chk(bus_rd, e);
  endtask

  task automatic rc(input tcl_rf_cmd_e c, input logic [7:0] d, e);
    @(posedge clk) rf <= '{1'h1, c, d};
    @(posedge clk) rf.valid <= 1'h0;
    #1 chk(rf_ack, 1'h1);
    chk(rf_rd, e);
  endtask

  task automatic t_reset;
    #1 chk(wp, 16'h0000);
    chk(hv_en, 1'h1);
    chk(lvl, 2'h1);
    bw(1'h0, 1'h1, TCL_ADDR_CFG, 8'h00, 8'hF1, 1'h0);
    bw(1'h0, 1'h1, TCL_ADDR_CTRL, 8'h00, 8'h01, 1'h0);
  endtask

  task automatic t_wp;
    bw(1'h1, 1'h1, TCL_ADDR_WP_LO, 8'hA5, 8'h00, 1'h1);
    set_masks(1'h1, 1'h0, 1'h0);
    #1 chk(wp, 16'h0000);
    bw(1'h1, 1'h1, TCL_ADDR_WP_LO, 8'hA5, 8'h00, 1'h0);
    bw(1'h1, 1'h1, TCL_ADDR_WP_HI, 8'h3C, 8'h00, 1'h0);
    set_masks(1'h0, 1'h0, 1'h0);
    #1 chk(wp, 16'h3CA5);
    bw(1'h0, 1'h1, TCL_ADDR_WP_HI, 8'h00, 8'h3C, 1'h0);
    bw(1'h0, 1'h1, 12'h912, 8'h00, 8'h00, 1'h1);
    bw(1'h0, 1'h0, TCL_ADDR_CFG, 8'h00, 8'h00, 1'h1);
  endtask

  task automatic t_rf_cfg;
    tcl_rf_model_inst.field(1'h1);
    rc(TCL_RF_WRITE_HV_CFG, 8'h06, 8'h00);
    chk(store, 1'h1);
    chk(store_d, 8'hF6);
    @(posedge clk) #1 chk(lvl, 2'h2);
    rc(TCL_RF_READ_CONFIG, 8'h00, 8'hF6);
    rc(TCL_RF_WRITE_PIN_CFG, 8'hFF, 8'h00);
    rc(TCL_RF_READ_CONFIG, 8'h00, 8'hFE);
    rc(TCL_RF_SET_HV_EN, 8'h00, 8'h00);
    @(posedge clk) #1 chk(hv_en, 1'h0);
    rc(TCL_RF_READ_CONTROL, 8'h00, 8'h02);
    bw(1'h1, 1'h1, TCL_ADDR_CTRL, 8'hFF, 8'h00, 1'h0);
    bw(1'h0, 1'h1, TCL_ADDR_CTRL, 8'h00, 8'h03, 1'h0);
    bw(1'h1, 1'h1, TCL_ADDR_CFG, 8'h01, 8'h00, 1'h0);
    chk(store, 1'h1);
    chk(store_d, 8'h01);
    bw(1'h0, 1'h1, TCL_ADDR_CFG, 8'h00, 8'h01, 1'h0);
  endtask

  task automatic t_done;
    wr_cycle(1'h1, 1'h0);
    wr_cycle(1'h0, 1'h1);
    bw(1'h0, 1'h1, TCL_ADDR_CTRL, 8'h00, 8'h83, 1'h0);
    rc(TCL_RF_READ_CONTROL, 8'h00, 8'h03);
    wr_cycle(1'h1, 1'h0);
    bw(1'h0, 1'h1, TCL_ADDR_CTRL, 8'h00, 8'h03, 1'h0);
    wr_cycle(1'h1, 1'h1);
    bw(1'h0, 1'h1, TCL_ADDR_CTRL, 8'h00, 8'h83, 1'h0);
  endtask

  task automatic t_pin;
    tcl_rf_model_inst.pulse(6'h20);
    #1 chk(pin, 1'h1);
    tcl_rf_model_inst.pulse(6'h10);
    #1 chk(pin, 1'h1);
    tcl_rf_model_inst.pulse(6'h04);
    #1 chk(pin, 1'h0);
    tcl_rf_model_inst.pulse(6'h20);
    tcl_rf_model_inst.pulse(6'h18);
    #1 chk(pin, 1'h0);
    tcl_rf_model_inst.pulse(6'h20);
    set_masks(1'h0, 1'h1, 1'h0);
    @(posedge clk) #1 chk(pin, 1'h0);
    set_masks(1'h0, 1'h0, 1'h0);
    @(posedge clk) #1 chk(pin, 1'h1);
    tcl_rf_model_inst.field(1'h0);
    #1 chk(pin, 1'h0);
    tcl_rf_model_inst.field(1'h1);
    bw(1'h1, 1'h1, TCL_ADDR_CFG, 8'h09, 8'h00, 1'h0);
    tcl_rf_model_inst.pulse(6'h20);
    #1 chk(pin, 1'h0);
    tcl_rf_model_inst.pulse(6'h02);
    #1 chk(pin, 1'h1);
    set_masks(1'h0, 1'h1, 1'h1);
    @(posedge clk) #1 chk(pin, 1'h0);
    set_masks(1'h0, 1'h0, 1'h0);
    @(posedge clk) #1 chk(pin, 1'h1);
    tcl_rf_model_inst.pulse(6'h01);
    #1 chk(pin, 1'h0);
  endtask

  // Mid-run reset with harvest default-off set and the other level pair
  task automatic t_rst2;
    @(posedge clk);
    apply_reset(8'h0F);
    #1 chk(wp, 16'h0000);
    chk(hv_en, 1'h0);
    chk(lvl, 2'h3);
    chk(pin, 1'h0);
    bw(1'h0, 1'h1, TCL_ADDR_CFG, 8'h00, 8'h0F, 1'h0);
    bw(1'h0, 1'h1, TCL_ADDR_CTRL, 8'h00, 8'h02, 1'h0);
  endtask

  initial begin
    {pwd, cmd_act, wr_act, wr_start, wr_ok} = 5'h00;
    bus = '0;
    rf = '0;
    err_count = 0;
    checked = 0;
    apply_reset(8'hF1);
    t_reset;
    t_wp;
    t_rf_cfg;
    t_done;
    t_pin;
    t_rst2;
    report_and_stop;
  end

  // Whole run is under two hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    report_and_stop;
  end
endmodule // tb
